/* core/tab_pkg.sv */
// types for the trip aggregation block
`include "tab_regs.svh"
package tab_pkg;
   typedef struct packed {
      logic [`TAB_STAGES-1:0]                     crit;
      logic [`TAB_STAGES-1:0]                     stageTrip;
      logic [`TAB_STAGES-1:0][`TAB_DELAY_W-1:0]  timer;
      logic                                       genAlarm;
      logic                                       genTrip;
      logic                                       genTripLast;
      logic [`TAB_STAGES-1:0]                     cmd;
      logic [`TAB_STAGES-1:0]                     alarm;
      logic                                       available;
      logic                                       protBlocked;
      logic [`TAB_FCOUNT_W-1:0]                   faultCount;
   } tab_state_t;
endpackage : tab_pkg

/* core/tab_regs.svh */
// stage count and width constants for the trip aggregation block
`ifndef TAB_REGS_SVH
`define TAB_REGS_SVH
`define TAB_STAGES      4
`define TAB_DELAY_W     16
`define TAB_FCOUNT_W    16
`endif

/* core/tab_trip_aggregation.sv */
// master protection supervision: gating, blocking and alarm/trip aggregation
// Summary of operation
// RULE1: inactive global enable or master block suppresses every protective output.
// RULE2: available only when no setting edit, measurements valid and enable active.
// RULE3: with permit, either block input blocks all protection until both clear.
// RULE4: permanent command block suppresses trip commands; alarms and trips still evaluated.
// RULE5: with permit, temporary block input suppresses trip commands while true.
// RULE6: any active, trip-authorised stage that trips raises general trip.
// RULE7: general alarm is OR of contributing stage alarms.
// RULE8: general trip is OR of contributing stage trips.
// RULE9: stage command needs trip, not supervision-only, not deactivated or blocked.
// RULE10: supervision-only stage forwards nothing and never opens the breaker.
// RULE11: alarm becomes trip only if criterion persists past stage delay.
// RULE12: fault counter counts general trip rising edges; clear command zeroes it.
`timescale 1ns/1ps
`default_nettype none
`include "tab_regs.svh"
module tab_trip_aggregation (
   // clock and reset
   input  wire logic                                    clock,
   input  wire logic                                    rst,
   // global settings
   input  wire logic                                    globalEnable,
   input  wire logic                                    settingEditActive,
   input  wire logic                                    measValid,
   input  wire logic                                    ext_block_permit,
   input  wire logic                                    block_input_a,
   input  wire logic                                    block_input_b,
   input  wire logic                                    perm_command_block,
   input  wire logic                                    temp_command_block_permit,
   input  wire logic                                    temp_command_block_input,
   input  wire logic                                    fault_count_clear,
   // per-stage settings and fault criteria
   input  wire logic [`TAB_STAGES-1:0]                  stageActive,
   input  wire logic [`TAB_STAGES-1:0]                  supervOnly,
   input  wire logic [`TAB_STAGES-1:0]                  stageCmdBlock,
   input  wire logic [`TAB_STAGES-1:0]                  faultCriterion,
   input  wire logic [`TAB_STAGES-1:0][`TAB_DELAY_W-1:0] stageDelay,
   // outputs
   output logic [`TAB_STAGES-1:0]                       stageAlarm,
   output logic [`TAB_STAGES-1:0]                       stageTrip,
   output logic [`TAB_STAGES-1:0]                       breaker_open_command,
   output logic                                         generalAlarm,
   output logic                                         generalTrip,
   output logic                                         protAvailable,
   output logic                                         protBlocked,
   output logic [`TAB_FCOUNT_W-1:0]                     faultCount
);
   // global inputs and fault criteria pass two flip-flops; per-stage settings do not
   localparam int NS = `TAB_STAGES;
   localparam logic [`TAB_DELAY_W-1:0]  TIMER_ONE = {{(`TAB_DELAY_W-1){1'b0}}, 1'b1};
   localparam logic [`TAB_FCOUNT_W-1:0] COUNT_ONE = {{(`TAB_FCOUNT_W-1){1'b0}}, 1'b1};
   logic [NS+9:0]        syncA_ff;
   logic [NS+9:0]        syncB_ff;
   tab_pkg::tab_state_t  cur_ff;
   tab_pkg::tab_state_t  nxt_cur;
   logic                 gEn;
   logic                 edit;
   logic                 mOk;
   logic                 exPermit;
   logic                 blkA;
   logic                 blkB;
   logic                 permBlk;
   logic                 tPermit;
   logic                 tIn;
   logic                 fcClr;
   logic [NS-1:0]        crit;

   always_ff @(posedge clock) begin
      if (rst) begin
         syncA_ff <= '0;
         syncB_ff <= '0;
      end else begin
         syncA_ff <= {faultCriterion,
                      globalEnable,
                      settingEditActive,
                      measValid,
                      ext_block_permit,
                      block_input_a,
                      block_input_b,
                      perm_command_block,
                      temp_command_block_permit,
                      temp_command_block_input,
                      fault_count_clear};
         syncB_ff <= syncA_ff;
      end
   end
   // only the second stage feeds the logic
   assign {crit,
           gEn,
           edit,
           mOk,
           exPermit,
           blkA,
           blkB,
           permBlk,
           tPermit,
           tIn,
           fcClr} = syncB_ff;

   // block and command-block decode
   logic blocked, enabled, cmdBlocked;
   logic [NS-1:0] contribute;
   assign blocked    = exPermit && (blkA || blkB);                 // see RULE3
   assign enabled    = gEn && !blocked;                            // see RULE1
   assign cmdBlocked = permBlk || (tPermit && tIn);                // see RULE4 see RULE5
   assign contribute = stageActive & ~supervOnly;                  // see RULE10

   // stage timers, trips and general outputs
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.crit = crit;
      nxt_cur.alarm = crit & stageActive & {NS{enabled}};               // see RULE1
      for (int i = 0; i < NS; i++) begin
         if (!enabled || !stageActive[i] || !crit[i]) begin
            nxt_cur.timer[i]     = '0;
            nxt_cur.stageTrip[i] = 1'b0;
         end else if (cur_ff.timer[i] >= stageDelay[i]) begin
            nxt_cur.stageTrip[i] = 1'b1;                           // see RULE11
         end else begin
            nxt_cur.timer[i] = cur_ff.timer[i] + TIMER_ONE;
         end
      end
      nxt_cur.genAlarm    = |(cur_ff.crit & contribute) && enabled;      // see RULE7
      nxt_cur.genTrip     = |(cur_ff.stageTrip & contribute) && enabled; // see RULE6 see RULE8
      nxt_cur.cmd         = (cmdBlocked || !enabled) ? '0 :
                            (cur_ff.stageTrip & contribute & ~stageCmdBlock); // see RULE9
      nxt_cur.available   = !edit && mOk && gEn;                   // see RULE2
      nxt_cur.protBlocked = blocked;
      nxt_cur.genTripLast = cur_ff.genTrip;
      // an edge in the clearing cycle is still counted
      if (fcClr)
         nxt_cur.faultCount = '0;                                  // see RULE12
      if (cur_ff.genTrip && !cur_ff.genTripLast)
         nxt_cur.faultCount = nxt_cur.faultCount + COUNT_ONE;      // see RULE12
   end

   // state register
   always_ff @(posedge clock) begin
      if (rst) cur_ff <= '0;
      else     cur_ff <= nxt_cur;
   end

   // outputs straight from the state register
   assign stageAlarm           = cur_ff.alarm;
   assign stageTrip            = cur_ff.stageTrip;
   assign breaker_open_command = cur_ff.cmd;
   assign generalAlarm         = cur_ff.genAlarm;
   assign generalTrip          = cur_ff.genTrip;
   assign protAvailable        = cur_ff.available;
   assign protBlocked          = cur_ff.protBlocked;
   assign faultCount           = cur_ff.faultCount;

   // assertions
   disable_all_a: assert property (@(posedge clock) disable iff (rst) // see RULE1
      !gEn |=> !generalTrip && !generalAlarm && breaker_open_command == '0)
      else $error("output active while disabled");
   blocked_quiet_a: assert property (@(posedge clock) disable iff (rst) // see RULE1
      !enabled |=> stageTrip == '0 && stageAlarm == '0 && breaker_open_command == '0)
      else $error("stage output while blocked");
   timer_clear_a: assert property (@(posedge clock) disable iff (rst) // see RULE1
      !enabled |=> cur_ff.timer == '0)
      else $error("timer running while disabled");
   alarm_enable_a: assert property (@(posedge clock) disable iff (rst) // see RULE1
      stageAlarm != '0 |-> $past(enabled))
      else $error("stage alarm while disabled");
   avail_cond_a: assert property (@(posedge clock) disable iff (rst) // see RULE2
      protAvailable == $past(!edit && mOk && gEn))
      else $error("availability mismatch");
   edit_unavail_a: assert property (@(posedge clock) disable iff (rst) // see RULE2
      edit |=> !protAvailable)
      else $error("available during setting edit");
   ext_block_a: assert property (@(posedge clock) disable iff (rst) // see RULE3
      (exPermit && (blkA || blkB)) |=> !generalTrip && protBlocked)
      else $error("external block ignored");
   block_release_a: assert property (@(posedge clock) disable iff (rst) // see RULE3
      !(exPermit && (blkA || blkB)) |=> !protBlocked)
      else $error("block held after release");
   perm_cmd_a: assert property (@(posedge clock) disable iff (rst) // see RULE4
      permBlk |=> breaker_open_command == '0)
      else $error("command while permanently blocked");
   perm_eval_a: assert property (@(posedge clock) disable iff (rst) // see RULE4
      (permBlk && enabled && |(stageTrip & contribute)) |=> generalTrip)
      else $error("trip not evaluated under command block");
   temp_cmd_a: assert property (@(posedge clock) disable iff (rst) // see RULE5
      (tPermit && tIn) |=> breaker_open_command == '0)
      else $error("command while temporarily blocked");
   gen_trip_a: assert property (@(posedge clock) disable iff (rst) // see RULE6 see RULE8
      (|(stageTrip & contribute) && enabled) |=> generalTrip)
      else $error("general trip missing");
   trip_cause_a: assert property (@(posedge clock) disable iff (rst) // see RULE8
      generalTrip |-> $past(|(stageTrip & contribute)))
      else $error("spurious general trip");
   gen_alarm_a: assert property (@(posedge clock) disable iff (rst) // see RULE7
      generalAlarm |-> $past(|(cur_ff.crit & contribute)))
      else $error("spurious general alarm");
   stage_cmd_a: assert property (@(posedge clock) disable iff (rst) // see RULE9
      breaker_open_command != '0 |->
         $past(|(stageTrip & ~supervOnly & ~stageCmdBlock)))
      else $error("command without cause");
   cmd_blocked_a: assert property (@(posedge clock) disable iff (rst) // see RULE9
      stageCmdBlock[0] |=> !breaker_open_command[0])
      else $error("command from blocked stage");
   superv_only_a: assert property (@(posedge clock) disable iff (rst) // see RULE10
      supervOnly[0] |=> !breaker_open_command[0])
      else $error("supervision stage operated");
   trip_delay_a: assert property (@(posedge clock) disable iff (rst) // see RULE11
      $rose(stageTrip[0]) |-> $past(cur_ff.timer[0]) >= $past(stageDelay[0]))
      else $error("trip before delay");
   trip_drop_a: assert property (@(posedge clock) disable iff (rst) // see RULE11
      !crit[0] |=> !stageTrip[0])
      else $error("trip held without criterion");
   fault_count_a: assert property (@(posedge clock) disable iff (rst) // see RULE12
      (cur_ff.genTrip && !cur_ff.genTripLast) |=>
         faultCount == ($past(fcClr) ? COUNT_ONE : $past(faultCount) + COUNT_ONE))
      else $error("fault count not incremented");
   fault_clear_a: assert property (@(posedge clock) disable iff (rst) // see RULE12
      (fcClr && !(cur_ff.genTrip && !cur_ff.genTripLast)) |=> faultCount == '0)
      else $error("fault count not cleared");
   // main scenarios
   trip_seen_c:  cover property (@(posedge clock) disable iff (rst) $rose(generalTrip));
   cmd_seen_c:   cover property (@(posedge clock) disable iff (rst) |breaker_open_command);
   block_seen_c: cover property (@(posedge clock) disable iff (rst) $rose(protBlocked));
   clear_seen_c: cover property (@(posedge clock) disable iff (rst) fcClr && faultCount != '0);
   alarm_only_c: cover property (@(posedge clock) disable iff (rst) generalAlarm && !generalTrip);
endmodule : tab_trip_aggregation
`default_nettype wire

/* verif/tab_stage_model.sv */
// fault criterion lines of the protection stages
`timescale 1ns/1ps
`default_nettype none
`include "tab_regs.svh"
module tab_stage_model (
   // clock
   input  wire logic                   clock,
   // commanded faults and criterion lines
   input  wire logic [`TAB_STAGES-1:0] faultReq,
   output logic      [`TAB_STAGES-1:0] faultCriterion
);
   always_ff @(posedge clock) begin
      faultCriterion <= faultReq;
   end
endmodule : tab_stage_model
`default_nettype wire

/* verif/trip_aggregation_and_blocking_bench.sv */
// self-checking bench for the trip aggregation block
`timescale 1ns/1ps
`default_nettype none
`include "tab_regs.svh"
module trip_aggregation_and_blocking_bench;
   logic                                     clock, rst, clr, gAlarm, gTrip, avail, blocked;
   logic [13:0]                              cfg;
   logic [3:0]                               cmdBlk, crit, sTrip, cmd, act, sAlarm;
   logic [4:0]                               flags;
   logic [`TAB_STAGES-1:0][`TAB_DELAY_W-1:0] dly;
   logic [15:0]                              fCount;
   int                                       nErrors, numChecks;
   // enable edit valid permit a b perm tpermit tinput superv0 crit[3:0]
   logic [13:0] rin [13] = '{14'h2801, 14'h0801, 14'h3800, 14'h2000, 14'h2e01, 14'h2d01,
      14'h2a01, 14'h2881, 14'h2861, 14'h2821, 14'h2811, 14'h2804, 14'h281f};
   // alarm trip anyCommand available blocked
   logic [4:0] rexp [13] = '{5'h1e, 5'h00, 5'h00, 5'h00, 5'h03, 5'h03,
      5'h1e, 5'h1a, 5'h1a, 5'h1e, 5'h02, 5'h1e, 5'h1e};
   tab_trip_aggregation i_tab_trip_aggregation (.clock(clock), .rst(rst),
      .globalEnable(cfg[13]), .settingEditActive(cfg[12]), .measValid(cfg[11]),
      .ext_block_permit(cfg[10]), .block_input_a(cfg[9]), .block_input_b(cfg[8]),
      .perm_command_block(cfg[7]), .temp_command_block_permit(cfg[6]),
      .temp_command_block_input(cfg[5]), .fault_count_clear(clr), .stageActive(act),
      .supervOnly({3'h0, cfg[4]}), .stageCmdBlock(cmdBlk), .faultCriterion(crit),
      .stageDelay(dly), .stageAlarm(sAlarm), .stageTrip(sTrip), .breaker_open_command(cmd),
      .generalAlarm(gAlarm), .generalTrip(gTrip), .protAvailable(avail),
      .protBlocked(blocked), .faultCount(fCount));
   tab_stage_model i_tab_stage_model (.clock(clock), .faultReq(cfg[3:0]), .faultCriterion(crit));
   assign flags = {gAlarm, gTrip, |cmd, avail, blocked};
   task automatic chkf(input logic [4:0] got, input logic [4:0] exp);
      numChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkf
   task automatic chkc(input logic [15:0] got, input logic [15:0] exp);
      numChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkc
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      rst = 1'b1;
      clr = 1'b0;
      cfg = 14'h0000;
      cmdBlk = 4'h0;
      act = 4'hf;
      dly = '0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 13; i++) begin
         @(posedge clock);
         cfg <= rin[i];
         step(12);
         chkf(flags, rexp[i]);
      end
      @(posedge clock);
      cfg <= 14'h2801;
      cmdBlk <= 4'h1;
      step(12);
      chkf(flags, 5'h1a);
      @(posedge clock);
      cmdBlk <= 4'h0;
      cfg <= 14'h2800;
      step(12);
      @(posedge clock);
      dly[0] <= 16'h0014;
      cfg <= 14'h2801;
      step(12);
      chkf(flags, 5'h12);
      step(25);
      chkf({gAlarm, gTrip, sTrip[0], avail, blocked}, 5'h1e);
      @(posedge clock);
      dly[0] <= 16'h0000;
      clr <= 1'b1;
      step(6);
      chkc(fCount, 16'h0000);
      @(posedge clock);
      clr <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         @(posedge clock);
         cfg <= 14'h2800;
         step(12);
         @(posedge clock);
         cfg <= 14'h2801;
         step(12);
      end
      chkc(fCount, 16'h0003);
      chkf({1'b0, sAlarm}, 5'h01);
      // stage 0 switched off while its criterion stands
      @(posedge clock);
      act <= 4'he;
      step(12);
      chkf({1'b0, sAlarm}, 5'h00);
      chkf(flags, 5'h02);
      // mid-run reset, then release with a standing fault
      @(posedge clock);
      rst <= 1'b1;
      act <= 4'hf;
      step(2);
      chkf(flags, 5'h00);
      chkc(fCount, 16'h0000);
      @(posedge clock);
      rst <= 1'b0;
      step(1);
      chkf(flags, 5'h00);
      chkc({12'h000, sAlarm}, 16'h0000);
      step(12);
      chkf(flags, 5'h1e);
      chkc(fCount, 16'h0001);
      tally_and_finish();
   end
endmodule : trip_aggregation_and_blocking_bench
`default_nettype wire
